// ### rtl/pims_pkg.sv
// shared codes and widths for the element message sequencer
package pims_pkg;
  localparam int PAY_W  = 16;   // message payload width
  localparam int NPE    = 4;    // processing elements on the bus
  localparam int NSLOT  = 8;    // broadcast slots per cycle
  localparam int SYNC_W = PAY_W + 3;

  typedef logic [PAY_W-1:0] pims_word_type;

  // major modes as seen on mode_i
  localparam logic [2:0] MODE_SELF_TEST = 3'h0;
  localparam logic [2:0] MODE_DETECT    = 3'h1;
  localparam logic [2:0] MODE_INIT      = 3'h2;
  localparam logic [2:0] MODE_JOIN      = 3'h3;
  localparam logic [2:0] MODE_PRESERVE  = 3'h4;

  // schedule assessment from the voting logic
  localparam logic [1:0] ASM_OK   = 2'h0;
  localparam logic [1:0] ASM_ZERO = 2'h1;
  localparam logic [1:0] ASM_BAD  = 2'h2;

  // broadcast result kinds
  localparam logic [1:0] RK_DATA  = 2'h0;
  localparam logic [1:0] RK_ELEM  = 2'h1;
  localparam logic [1:0] RK_SRC   = 2'h2;
  localparam logic [1:0] RK_SPLIT = 2'h3;

  // control payload codes (fixed by this design)
  localparam pims_word_type C_SELF_TEST  = 16'h0001;
  localparam pims_word_type C_DETECT     = 16'h0002;
  localparam pims_word_type C_INIT_GRP   = 16'h0003;
  localparam pims_word_type C_JOIN       = 16'h0004;
  localparam pims_word_type C_PRESERVE   = 16'h0005;
  localparam pims_word_type C_ELEM_FAULT = 16'h0010;
  localparam pims_word_type C_SRC_ERR    = 16'h0011;
  localparam pims_word_type C_VOTE_SPLIT = 16'h0012;
  localparam pims_word_type C_SCHED_OK   = 16'h0020;
  localparam pims_word_type C_SCHED_ZERO = 16'h0021;
  localparam pims_word_type C_SCHED_BAD  = 16'h0022;
  localparam pims_word_type C_REF_INIT   = 16'h0030;
  localparam pims_word_type C_REF_ECHO   = 16'h0031;

  // sequencer states, one-hot
  typedef enum logic [10:0] {
    ST_IDLE  = 11'h001,
    ST_MODE  = 11'h002,
    ST_IDENT = 11'h004,
    ST_SU_RD = 11'h008,
    ST_SU_RS = 11'h010,
    ST_SU_AS = 11'h020,
    ST_BC_RD = 11'h040,
    ST_BC_RS = 11'h080,
    ST_REF   = 11'h100,
    ST_DG1   = 11'h200,
    ST_DG2   = 11'h400
  } pims_state_type;

  // payload that names a mode
  function automatic pims_word_type mode_code(input logic [2:0] m);
    case (m)
      MODE_SELF_TEST: mode_code = C_SELF_TEST;
      MODE_DETECT:    mode_code = C_DETECT;
      MODE_INIT:      mode_code = C_INIT_GRP;
      MODE_JOIN:      mode_code = C_JOIN;
      default:        mode_code = C_PRESERVE;
    endcase
  endfunction

  // payload of one broadcast result
  function automatic pims_word_type res_code(input logic [1:0] k,
                                             input pims_word_type d);
    case (k)
      RK_ELEM:  res_code = C_ELEM_FAULT;
      RK_SRC:   res_code = C_SRC_ERR;
      RK_SPLIT: res_code = C_VOTE_SPLIT;
      default:  res_code = d;
    endcase
  endfunction
endpackage

// ### rtl/pims_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pims_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] in_i,
  output logic      [W-1:0] out_o
);
  logic [W-1:0] s1_q;  // metastability catcher, read only by s2_q
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_o <= '0;
    end
    else
    begin
      s1_q  <= in_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_o <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_o);
    end
  end
endmodule
`default_nettype wire

// ### rtl/pims_sequencer.sv
// message sequencer between the bus interface unit and its element
// How it works
// R1: element sends only data, two services
// R2: element data read and forwarded to bus
// R3: missing or invalid input becomes fault code
// R4: mode message on transitions and join cycles
// R5: mode message is control naming mode
// R6: identification message carries unit number
// R7: mode, identification follow diagnosis in join
// R8: schedule read, then per-element results out
// R9: one assessment message closes schedule update
// R10: invalid schedule selects default schedule
// R11: zero schedule skips broadcast service
// R12: broadcast reads own slots, outputs all results
// R13: result codes: element, source, vote split
// R14: reference event emits init reference message
// R15: acquisition phases emit echo reference instead
// R16: two diagnosis messages end the cycle
// R17: element input ready by read instant
// R18: element expects output only once generated
// R19: transfers keep tick-exact schedule
// R20: input is fifo, present or flagged
// R21: outputs pushed without readiness handshake
// R22: failure on either side requests common reset
// R23: type flag separates data and control
`timescale 1ns/100ps
`default_nettype none
module pims_sequencer
  import pims_pkg::*;
#(
  parameter int N_PE   = pims_pkg::NPE,
  parameter int N_SLOT = pims_pkg::NSLOT
)
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  pe_valid_i,    // element pin
  input  wire logic                  pe_err_i,      // element pin
  input  wire logic [PAY_W-1:0]      pe_data_i,     // element pins
  input  wire logic                  pe_fault_i,    // element pin
  input  wire logic                  unit_fail_i,
  input  wire logic [2:0]            mode_i,
  input  wire logic                  mode_change_i,
  input  wire logic                  sync_acq_i,
  input  wire logic [PAY_W-1:0]      unit_id_i,
  input  wire logic                  svc_su_i,
  input  wire logic                  svc_bc_i,
  input  wire logic                  svc_ref_i,
  input  wire logic                  svc_diag_i,
  input  wire logic [PAY_W-1:0]      sched_res_i,
  input  wire logic [1:0]            assess_i,
  input  wire logic                  bc_own_i,
  input  wire logic [1:0]            bc_kind_i,
  input  wire logic [PAY_W-1:0]      bc_data_i,
  input  wire logic [PAY_W-1:0]      diag_unit_i,
  input  wire logic [PAY_W-1:0]      diag_relay_i,
  output logic                       pe_pop_o,
  output logic                       pe_msg_valid_o,
  output logic                       pe_msg_ctrl_o,
  output logic [PAY_W-1:0]           pe_msg_data_o,
  output logic                       bus_valid_o,
  output logic                       bus_ctrl_o,
  output logic [PAY_W-1:0]           bus_data_o,
  output logic [$clog2(N_SLOT)-1:0]  sel_o,
  output logic                       default_sched_o,
  output logic                       common_reset_o,
  output logic                       busy_o
);
  import pims_pkg::*;

  localparam int IW = $clog2(N_SLOT);
  localparam logic [IW-1:0] PE_LAST   = IW'(N_PE - 1);
  localparam logic [IW-1:0] SLOT_LAST = IW'(N_SLOT - 1);
  localparam logic [IW-1:0] IDX_ONE   = IW'(1);

  pims_state_type state_q;      // sequencer state
  pims_state_type state_d;
  logic           id_pend_q;    // identification owed after mode
  logic           mode_pend_q;  // mode message owed after transition
  logic           skip_q;       // zero schedule: no broadcast
  logic [IW-1:0]  idx_q;        // element or slot index
  logic [SYNC_W-1:0] sync_s;    // synchronised element pins

  // element pins come from another fault region, so resynchronise
  pims_sync #(.W(SYNC_W)) u_sync
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .in_i      ({pe_fault_i, pe_err_i, pe_valid_i, pe_data_i}),
    .out_o     (sync_s)
  );

  wire pims_word_type pe_d_s  = sync_s[PAY_W-1:0];
  wire                pe_v_s  = sync_s[PAY_W];
  wire                pe_e_s  = sync_s[PAY_W+1];
  wire                pe_f_s  = sync_s[PAY_W+2];

  // state decodes
  wire st_idle  = (state_q == ST_IDLE);
  wire st_mode  = (state_q == ST_MODE);
  wire st_ident = (state_q == ST_IDENT);
  wire st_su_rd = (state_q == ST_SU_RD);
  wire st_su_rs = (state_q == ST_SU_RS);
  wire st_su_as = (state_q == ST_SU_AS);
  wire st_bc_rd = (state_q == ST_BC_RD);
  wire st_bc_rs = (state_q == ST_BC_RS);
  wire st_ref   = (state_q == ST_REF);
  wire st_dg1   = (state_q == ST_DG1);
  wire st_dg2   = (state_q == ST_DG2);

  wire join_pres = (mode_i == MODE_JOIN) || (mode_i == MODE_PRESERVE);
  wire pe_last   = (idx_q == PE_LAST);
  wire slot_last = (idx_q == SLOT_LAST);

  // fifo view of the input: the word is read at its slot whether or
  // not the element got it there; an absent word is never waited for
  wire rd_now = st_su_rd | (st_bc_rd & bc_own_i);          // R20 R17
  wire pe_ok  = pe_v_s & ~pe_e_s;                          // R3

  // next state: one message per cycle keeps the tick schedule fixed
  always_comb
  begin
    state_d = state_q;                                     // R19
    unique case (state_q)
      ST_IDLE:
      begin
        if (svc_ref_i)
          state_d = ST_REF;                                // R14
        else if (svc_diag_i)
          state_d = ST_DG1;                                // R16
        else if (svc_su_i)
          state_d = ST_SU_RD;                              // R8
        else if (svc_bc_i && !skip_q)
          state_d = ST_BC_RD;                              // R11
        else if (mode_pend_q)
          state_d = ST_MODE;                               // R4
      end
      ST_MODE:
        state_d = id_pend_q ? ST_IDENT : ST_IDLE;          // R7
      ST_IDENT:
        state_d = ST_IDLE;
      ST_SU_RD:
        state_d = ST_SU_RS;                                // R8
      ST_SU_RS:
        state_d = pe_last ? ST_SU_AS : ST_SU_RS;           // R9
      ST_SU_AS:
        state_d = ST_IDLE;
      ST_BC_RD:
        state_d = ST_BC_RS;                                // R12
      ST_BC_RS:
        state_d = slot_last ? ST_IDLE : ST_BC_RD;
      ST_REF:
        state_d = ST_IDLE;
      ST_DG1:
        state_d = ST_DG2;                                  // R16
      ST_DG2:
        state_d = join_pres ? ST_MODE : ST_IDLE;           // R7
      default:
        state_d = ST_IDLE;
    endcase
  end

  // outgoing message toward the element
  wire out_v = st_mode | st_ident | st_su_rs | st_su_as | st_bc_rs
             | st_ref | st_dg1 | st_dg2;
  wire out_c = st_mode | st_su_as | st_ref
             | (st_bc_rs & (bc_kind_i != RK_DATA));        // R23

  wire pims_word_type asm_code =
    (assess_i == ASM_ZERO) ? C_SCHED_ZERO :
    (assess_i == ASM_BAD)  ? C_SCHED_BAD  : C_SCHED_OK;    // R9
  wire pims_word_type ref_code =
    sync_acq_i ? C_REF_ECHO : C_REF_INIT;                  // R14 R15

  wire pims_word_type out_w =
    st_mode  ? mode_code(mode_i) :                         // R5
    st_ident ? unit_id_i :                                 // R6
    st_su_rs ? sched_res_i :                               // R8
    st_su_as ? asm_code :
    st_bc_rs ? res_code(bc_kind_i, bc_data_i) :            // R13
    st_ref   ? ref_code :
    st_dg1   ? diag_unit_i :                               // R16
    st_dg2   ? diag_relay_i : '0;

  // word handed to the bus: element data, or the fault code instead
  wire pims_word_type bus_w = pe_ok ? pe_d_s : C_ELEM_FAULT; // R2 R3

  // index walks elements in schedule update and slots in broadcast
  wire idx_clr  = st_idle | st_su_rd;
  wire idx_step = st_su_rs | st_bc_rs;

  // sequencer state and bookkeeping
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_IDLE;
      idx_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (idx_clr)
        idx_q <= '0;
      else if (idx_step)
        idx_q <= idx_q + IDX_ONE;
    end
  end

  // owed messages; a new request wins over the clear in one cycle
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      mode_pend_q <= 1'b0;
      id_pend_q   <= 1'b0;
    end
    else
    begin
      mode_pend_q <= mode_change_i | (mode_pend_q & ~st_mode); // R4
      id_pend_q   <= (st_dg2 & join_pres)
                   | (id_pend_q & ~st_ident);              // R7
    end
  end

  // schedule assessment side effects hold until the next assessment
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      skip_q          <= 1'b0;
      default_sched_o <= 1'b0;
    end
    else if (st_su_as)
    begin
      skip_q          <= (assess_i == ASM_ZERO);           // R11
      default_sched_o <= (assess_i == ASM_BAD);            // R10
    end
  end

  // pushed outputs: no readiness from the element is consulted
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pe_msg_valid_o <= 1'b0;
      pe_msg_ctrl_o  <= 1'b0;
      pe_msg_data_o  <= '0;
      bus_valid_o    <= 1'b0;
      bus_ctrl_o     <= 1'b0;
      bus_data_o     <= '0;
      pe_pop_o       <= 1'b0;
    end
    else
    begin
      pe_msg_valid_o <= out_v;                             // R21
      pe_msg_ctrl_o  <= out_c;
      pe_msg_data_o  <= out_w;
      bus_valid_o    <= rd_now;                            // R2
      bus_ctrl_o     <= rd_now & ~pe_ok;                   // R3
      bus_data_o     <= rd_now ? bus_w : '0;
      pe_pop_o       <= rd_now;                            // R20
    end
  end

  // a failure on either side asks for a reset of both
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      common_reset_o <= 1'b0;
      busy_o         <= 1'b0;
      sel_o          <= '0;
    end
    else
    begin
      common_reset_o <= unit_fail_i | pe_f_s;              // R22
      busy_o         <= ~(state_d == ST_IDLE);
      sel_o          <= idx_clr ? '0 : idx_q + (idx_step ? IDX_ONE : '0);
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  mode_payload_a: assert property ( // R5
    st_mode |=> pe_msg_valid_o && pe_msg_ctrl_o
            && pe_msg_data_o == mode_code($past(mode_i)))
    else $error("mode message payload wrong");

  ident_payload_a: assert property ( // R6
    st_ident |=> pe_msg_valid_o && !pe_msg_ctrl_o
             && pe_msg_data_o == $past(unit_id_i))
    else $error("identification message wrong");

  fault_subst_a: assert property ( // R3
    rd_now && !pe_ok |=> bus_valid_o && bus_ctrl_o
                      && bus_data_o == C_ELEM_FAULT)
    else $error("missing input not substituted");

  data_forward_a: assert property ( // R2
    rd_now && pe_ok |=> bus_valid_o && !bus_ctrl_o
                     && bus_data_o == $past(pe_d_s) && pe_pop_o)
    else $error("element data not forwarded");

  diag_pair_a: assert property ( // R16
    st_dg1 |=> pe_msg_valid_o ##1 pe_msg_valid_o
           && pe_msg_data_o == $past(diag_relay_i))
    else $error("diagnosis pair not emitted");

  after_diag_a: assert property ( // R7
    st_dg2 && join_pres |=> st_mode ##1 st_ident ##1 st_idle)
    else $error("mode and identification not after diagnosis");

  zero_skip_a: assert property ( // R11
    skip_q |-> !st_bc_rd && !st_bc_rs)
    else $error("broadcast ran after zero schedule");

  default_sched_a: assert property ( // R10
    st_su_as && assess_i == ASM_BAD |=> default_sched_o [*2])
    else $error("default schedule not adopted");

  ref_payload_a: assert property ( // R14
    st_ref |=> pe_msg_ctrl_o && pe_msg_data_o ==
           ($past(sync_acq_i) ? C_REF_ECHO : C_REF_INIT))
    else $error("reference payload wrong");

  assess_once_a: assert property ( // R9
    st_su_rd |-> ##[1:16] st_su_as ##1 st_idle)
    else $error("assessment not closing update");

  common_reset_a: assert property ( // R22
    unit_fail_i |=> common_reset_o)
    else $error("common reset not requested");

  join_cycle_c: cover property (st_dg2 ##1 st_mode ##1 st_ident);
  zero_sched_c: cover property (st_su_as && assess_i == ASM_ZERO);
  subst_c:      cover property (rd_now && !pe_ok);
  bc_done_c:    cover property (st_bc_rs && slot_last);
endmodule
`default_nettype wire

// ### tb/pims_pe_model.sv
// behavioural processing element facing the message sequencer
`timescale 1ns/100ps
`default_nettype none
module pims_pe_model
  import pims_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           reset_n_i,
  input  wire logic           pop_i,        // word consumed by the unit
  input  wire logic           msg_valid_i,  // unit message pushed
  input  wire logic [1:0]     bad_i,        // 0 good, 1 flagged, 2 absent
  input  wire logic           fault_req_i,  // element failure seen
  output logic                valid_o,
  output logic                err_o,
  output logic [PAY_W-1:0]    data_o,
  output logic                fault_o,
  output logic [PAY_W-1:0]    word_o        // word now on offer
);
  logic [PAY_W-1:0] word_q;  // head of the element's queue
  logic             tog_q;   // scrambles released data lines
  int               rx_cnt;  // unit messages taken

  // element only offers plain data words, one in every cycle that bad_i does not mark absent
  assign valid_o = (bad_i != 2'h2);
  assign err_o   = (bad_i == 2'h1);
  // absent word: lines wander every cycle so stale data cannot match
  assign data_o  = valid_o ? word_q : (word_q ^ {PAY_W{tog_q}});
  assign word_o  = word_q;
  assign fault_o = fault_req_i;

  // next word is offered long before the next read instant
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      word_q <= 16'h5A31;
      tog_q  <= 1'b0;
      rx_cnt <= 0;
    end
    else
    begin
      tog_q <= ~tog_q;
      if (pop_i)
        word_q <= word_q + 16'h0107;
      if (msg_valid_i)
        rx_cnt <= rx_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/pe_interface_message_sequencer_tb.sv
// self-checking bench for the element message sequencer
`timescale 1ns/100ps
`default_nettype none
module pe_interface_message_sequencer_tb;
  import pims_pkg::*;
  logic clk_i, reset_n_i, unit_fail_i, mode_change_i, sync_acq_i;
  logic pe_valid, pe_err, pe_fault, fault_req, bc_own_i;
  logic [PAY_W-1:0] pe_data, pe_word, unit_id_i, sched_res_i, bc_data_i;
  logic [PAY_W-1:0] diag_unit_i, diag_relay_i, sbase, dbase;
  logic [2:0] mode_i, sel_o, own;
  logic [1:0] assess_i, bc_kind_i, bad, bshift;
  logic [4:0] strb;  // su, bc, ref, diag, mode change
  logic pe_pop_o, msg_v, msg_c, bus_v, bus_c, default_sched_o;
  logic common_reset_o, busy_o;
  logic [PAY_W-1:0] msg_d, bus_d;
  logic [16:0] rq[$], bq[$];  // {ctrl, data} seen on each side
  int rt[$];                  // cycle of each element message
  int cyc, t0, miscompares, cmp_count;
  int msg_total;              // element messages seen by the bench

  // far side answers combinationally from the slot index
  assign sched_res_i = sbase ^ PAY_W'(sel_o);
  assign bc_own_i    = (sel_o == own);
  assign bc_kind_i   = sel_o[1:0] + bshift;
  assign bc_data_i   = dbase ^ PAY_W'(sel_o);

  pims_sequencer dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .pe_valid_i(pe_valid), .pe_err_i(pe_err), .pe_data_i(pe_data),
    .pe_fault_i(pe_fault), .unit_fail_i(unit_fail_i), .mode_i(mode_i),
    .mode_change_i(strb[4]), .sync_acq_i(sync_acq_i),
    .unit_id_i(unit_id_i), .svc_su_i(strb[0]), .svc_bc_i(strb[1]),
    .svc_ref_i(strb[2]), .svc_diag_i(strb[3]), .sched_res_i(sched_res_i),
    .assess_i(assess_i), .bc_own_i(bc_own_i), .bc_kind_i(bc_kind_i),
    .bc_data_i(bc_data_i), .diag_unit_i(diag_unit_i),
    .diag_relay_i(diag_relay_i), .pe_pop_o(pe_pop_o),
    .pe_msg_valid_o(msg_v), .pe_msg_ctrl_o(msg_c), .pe_msg_data_o(msg_d),
    .bus_valid_o(bus_v), .bus_ctrl_o(bus_c), .bus_data_o(bus_d),
    .sel_o(sel_o), .default_sched_o(default_sched_o),
    .common_reset_o(common_reset_o), .busy_o(busy_o));

  pims_pe_model pe_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .pop_i(pe_pop_o), .msg_valid_i(msg_v), .bad_i(bad),
    .fault_req_i(fault_req), .valid_o(pe_valid), .err_o(pe_err),
    .data_o(pe_data), .fault_o(pe_fault), .word_o(pe_word));

  // expected payload naming a mode, kept apart from the design's table
  function automatic logic [PAY_W-1:0] exp_mode(input int m);
    case (m)
      0: return C_SELF_TEST;
      1: return C_DETECT;
      2: return C_INIT_GRP;
      3: return C_JOIN;
      default: return C_PRESERVE;
    endcase
  endfunction
  // expected broadcast result payload
  function automatic logic [PAY_W-1:0] exp_res(input int k,
                                               input logic [PAY_W-1:0] d);
    return (k == 1) ? C_ELEM_FAULT : (k == 2) ? C_SRC_ERR :
           (k == 3) ? C_VOTE_SPLIT : d;
  endfunction
  // captured message i, unknown when missing so it never matches
  function automatic logic [16:0] msg_at(input int i);
    return (i < rq.size()) ? rq[i] : 17'hX;
  endfunction

  task automatic chk_w(input logic [PAY_W-1:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_msg(input int i, input logic c,
                         input logic [PAY_W-1:0] d);
    logic [16:0] m;
    m = msg_at(i);
    chk_b(m[16], c);
    chk_w(m[15:0], d);
  endtask

  // one strobe, then wait for the sequencer to go quiet (bounded)
  task automatic run_svc(input int which);
    int n;
    rq.delete();
    rt.delete();
    bq.delete();
    @(negedge clk_i);
    t0 = cyc;
    strb = 5'h01 << which;
    @(negedge clk_i);
    strb = 5'h00;
    n = 0;
    repeat (2) @(negedge clk_i);
    while (busy_o !== 1'b0 && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_b(n < 200, 1'b1);
    repeat (4) @(negedge clk_i);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // 10 MHz clock and a cycle counter for tick-exact checks
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  // registered outputs stand one cycle: sample them settled
  always @(negedge clk_i)
  begin
    if (msg_v === 1'b1)
    begin
      msg_total++;
      rq.push_back({msg_c, msg_d});
      rt.push_back(cyc);
    end
    if (bus_v === 1'b1)
      bq.push_back({bus_c, bus_d});
  end

  // a hang counts as a mismatch and ends in the usual place
  initial
  begin
    #(100 * 20000);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    logic [PAY_W-1:0] w;
    int a, kd;
    cyc = 0; miscompares = 0; cmp_count = 0; strb = 5'h00;
    msg_total = 0;
    reset_n_i = 1'b0; unit_fail_i = 1'b0; sync_acq_i = 1'b0;
    fault_req = 1'b0; bad = 2'h0; mode_i = MODE_JOIN; own = 3'h0;
    assess_i = ASM_OK; bshift = 2'h0; sbase = '0; dbase = '0;
    diag_unit_i = '0; diag_relay_i = '0;
    void'($urandom(71));
    unit_id_i = PAY_W'($urandom);
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    // schedule update for each assessment, then a broadcast
    for (int k = 0; k < 6; k++)
    begin
      a = k % 3;
      bad = 2'((k + 1) % 3);
      repeat (8) @(negedge clk_i);
      sbase = PAY_W'($urandom);
      assess_i = (a == 0) ? ASM_OK : (a == 1) ? ASM_BAD : ASM_ZERO;
      w = pe_word;
      run_svc(0);
      chk_w(PAY_W'(bq.size()), 16'h0001);
      chk_b(bq.size() ? bq[0][16] : 1'bX, bad != 2'h0);
      chk_w(bq.size() ? bq[0][15:0] : 'X, bad ? C_ELEM_FAULT : w);
      for (int i = 0; i < NPE; i++)
        chk_msg(i, 1'b0, sbase ^ PAY_W'(i));
      chk_msg(NPE, 1'b1, (a == 0) ? C_SCHED_OK :
              (a == 1) ? C_SCHED_BAD : C_SCHED_ZERO);
      chk_w(PAY_W'(rq.size()), PAY_W'(NPE + 1));
      chk_b(default_sched_o, a == 1);
      bad = 2'h0;
      repeat (8) @(negedge clk_i);
      bshift = 2'($urandom);
      own = 3'($urandom);
      dbase = PAY_W'($urandom);
      run_svc(1);
      if (a == 2)
        chk_w(PAY_W'(rq.size() + bq.size()), 16'h0000);
      else
      begin
        for (int s = 0; s < NSLOT; s++)
        begin
          kd = (s + bshift) % 4;
          chk_msg(s, kd != 0, exp_res(kd, dbase ^ PAY_W'(s)));
        end
        chk_w(PAY_W'(bq.size()), 16'h0001);
      end
    end
    // time reference, plain and during acquisition, tick exact
    for (int s = 0; s < 2; s++)
    begin
      sync_acq_i = s[0];
      run_svc(2);
      chk_msg(0, 1'b1, s ? C_REF_ECHO : C_REF_INIT);
      chk_w(PAY_W'(rt.size() ? rt[0] - t0 : 0), 16'h0002);
    end
    // diagnosis in every mode; join and preservation add mode and id
    for (int m = 0; m < 5; m++)
    begin
      mode_i = 3'(m);
      diag_unit_i = PAY_W'($urandom);
      diag_relay_i = PAY_W'($urandom);
      run_svc(3);
      chk_msg(0, 1'b0, diag_unit_i);
      chk_msg(1, 1'b0, diag_relay_i);
      chk_w(PAY_W'(rq.size()), (m >= 3) ? 16'h0004 : 16'h0002);
      if (m >= 3)
      begin
        chk_msg(2, 1'b1, exp_mode(m));
        chk_msg(3, 1'b0, unit_id_i);
      end
    end
    // a major mode transition owes exactly one mode message
    for (int m = 0; m < 5; m++)
    begin
      mode_i = 3'(m);
      run_svc(4);
      chk_w(PAY_W'(rq.size()), 16'h0001);
      chk_msg(0, 1'b1, exp_mode(m));
    end
    // failure on either side requests the common reset
    unit_fail_i = 1'b1;
    @(negedge clk_i);
    unit_fail_i = 1'b0;
    chk_b(common_reset_o, 1'b1);
    @(negedge clk_i);
    chk_b(common_reset_o, 1'b0);
    fault_req = 1'b1;
    repeat (8) @(negedge clk_i);
    chk_b(common_reset_o, 1'b1);
    fault_req = 1'b0;
    repeat (8) @(negedge clk_i);
    chk_b(common_reset_o, 1'b0);
    // the element took every pushed message, none more, none fewer
    chk_w(PAY_W'(pe_u.rx_cnt), PAY_W'(msg_total));
    give_verdict();
  end
endmodule
`default_nettype wire
